// ===== stotr_regs.sv
// Purpose: Dual-channel timing trims and core A offset trims behind AXI4-Lite
// Assumes: Factory trim values arrive on static input ports
// Notes: Calibration access windows are reported, not enforced
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps

// Contract
// - Four 8-bit read/write timing trims at consecutive indices 0x086 to 0x089.
// - Separate trims for core A, spare for A, spare for B, core B.
// - After reset each trim holds its factory value; readable and writable.
// - Offset trims are 16 bits, low 12 value, upper 4 reserved reset zero.
// - Core A uses first-input offset on first input, second-input offset otherwise.
module stotr_regs (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [stotr_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [stotr_pkg::DATA_W-1:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [stotr_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [stotr_pkg::DATA_W-1:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [stotr_pkg::NUM_TIM*stotr_pkg::TIM_W-1:0] factory_timing_trim, // Factory timing trims
  input wire logic [stotr_pkg::OFF_W-1:0] factory_first_input_offset, // Factory first-input offset
  input wire logic [stotr_pkg::OFF_W-1:0] factory_second_input_offset, // Factory second-input offset
  input wire logic core_a_on_second_input, // Core A currently samples second input
  input wire logic foreground_cal_busy, // Foreground calibration running
  input wire logic background_calibration_enable, // Background calibration enabled
  input wire logic background_offset_calibration_enable, // Background offset calibration enabled
  input wire logic offset_calibration_enable, // Offset calibration enabled
  input wire logic foreground_done_flag, // Foreground calibration done
  input wire logic calibration_stopped_flag, // Background calibration stopped
  output logic [stotr_pkg::NUM_TIM*stotr_pkg::TIM_W-1:0] dual_timing_trim, // Timing trims, A, CA, CB, B
  output logic [stotr_pkg::OFF_VAL_W-1:0] core_a_offset_applied // Offset applied to core A
);
  import stotr_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] data,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  function automatic logic [IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] addr);
    word_idx = addr[ADDR_W-1:2];
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic loaded_q;
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [DATA_W-1:0] rdata_q;
  stotr_tim_t tim_q [NUM_TIM];
  stotr_off_t off_first_q;
  stotr_off_t off_second_q;
  logic [OFF_VAL_W-1:0] applied_q;
  logic viol_q;
  logic viol_d;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire do_write = aw_held_q && w_held_q && !bvalid_q;
  wire [IDX_W-1:0] wr_idx = word_idx(awaddr_q);
  wire [IDX_W-1:0] rd_idx = word_idx(s_axi_araddr);
  wire tim_wr_hit = (wr_idx >= IDX_CORE_A_DUAL_TIMING_TRIM) && (wr_idx <= IDX_CORE_B_DUAL_TIMING_TRIM);
  wire tim_rd_hit = (rd_idx >= IDX_CORE_A_DUAL_TIMING_TRIM) && (rd_idx <= IDX_CORE_B_DUAL_TIMING_TRIM);
  wire [1:0] tim_wr_sel = 2'(wr_idx - IDX_CORE_A_DUAL_TIMING_TRIM);
  wire [1:0] tim_rd_sel = 2'(rd_idx - IDX_CORE_A_DUAL_TIMING_TRIM);
  wire we_first = do_write && (wr_idx == IDX_CORE_A_FIRST_INPUT_OFFSET_TRIM);
  wire we_second = do_write && (wr_idx == IDX_CORE_A_SECOND_INPUT_OFFSET_TRIM);
  wire we_status = do_write && (wr_idx == IDX_CAL_ACCESS_STATUS);
  wire wr_mapped = tim_wr_hit || (wr_idx == IDX_CORE_A_FIRST_INPUT_OFFSET_TRIM) ||
                   (wr_idx == IDX_CORE_A_SECOND_INPUT_OFFSET_TRIM) || (wr_idx == IDX_CAL_ACCESS_STATUS);

  // Access windows for software; the bank never blocks, it only reports
  wire bg_both = background_calibration_enable && background_offset_calibration_enable;
  wire off_write_safe = !foreground_cal_busy && !bg_both;
  wire off_read_safe = (offset_calibration_enable && !background_offset_calibration_enable) ? foreground_done_flag :
                       bg_both ? calibration_stopped_flag : 1'b1;
  wire viol_set = (we_first || we_second) && !off_write_safe;
  wire viol_clr = we_status && wstrb_q[0] && wdata_q[ST_WRITE_VIOLATION];

  // Sticky: a new violation in the clearing cycle stays set
  always_comb begin
    viol_d = viol_set || (viol_q && !viol_clr);
  end

  wire [DATA_W-1:0] status_word = {27'h0000000, calibration_stopped_flag, foreground_done_flag, viol_q,
                                   off_read_safe, off_write_safe};
  wire rd_first = (rd_idx == IDX_CORE_A_FIRST_INPUT_OFFSET_TRIM);
  wire rd_second = (rd_idx == IDX_CORE_A_SECOND_INPUT_OFFSET_TRIM);
  wire rd_status = (rd_idx == IDX_CAL_ACCESS_STATUS);
  wire rd_mapped = tim_rd_hit || rd_first || rd_second || rd_status;
  wire [DATA_W-1:0] rd_word = tim_rd_hit ? {24'h000000, tim_q[tim_rd_sel]} :
                              rd_first ? {16'h0000, off_first_q} :
                              rd_second ? {16'h0000, off_second_q} :
                              rd_status ? status_word : 32'h00000000;

  // Ports stay closed during the factory load cycle so it cannot race a write
  assign s_axi_awready = loaded_q && !aw_held_q && !bvalid_q;
  assign s_axi_wready = loaded_q && !w_held_q && !bvalid_q;
  assign s_axi_arready = loaded_q && !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign core_a_offset_applied = applied_q;

  // ----------------------------------------------------------------
  // Bus channels
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (w_fire) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= rd_word;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Trim registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIM; gi++) begin : g_tim
      wire we_tim = do_write && tim_wr_hit && (tim_wr_sel == 2'(gi)) && wstrb_q[0];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          tim_q[gi] <= TIM_RESET;
        end else if (!loaded_q) begin
          tim_q[gi] <= factory_timing_trim[gi*TIM_W +: TIM_W];
        end else if (we_tim) begin
          tim_q[gi] <= wdata_q[TIM_W-1:0];
        end
      end
      assign dual_timing_trim[gi*TIM_W +: TIM_W] = tim_q[gi];
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      off_first_q <= OFF_RESET;
      off_second_q <= OFF_RESET;
    end else if (!loaded_q) begin
      off_first_q <= {OFF_RSVD_RESET, factory_first_input_offset[OFF_VAL_W-1:0]};
      off_second_q <= {OFF_RSVD_RESET, factory_second_input_offset[OFF_VAL_W-1:0]};
    end else begin
      if (we_first) begin
        off_first_q <= merge16(off_first_q, wdata_q[15:0], wstrb_q[1:0]);
      end
      if (we_second) begin
        off_second_q <= merge16(off_second_q, wdata_q[15:0], wstrb_q[1:0]);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      applied_q <= '0;
      viol_q <= 1'b0;
    end else begin
      applied_q <= core_a_on_second_input ? off_second_q[OFF_VAL_W-1:0] : off_first_q[OFF_VAL_W-1:0];
      viol_q <= viol_d;
    end
  end
endmodule

// ===== stotr_pkg.sv
// Purpose: Constants for the sampling timing and offset trim register bank
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: Register indices are kept as printed; byte address is four times the index
package stotr_pkg;
  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  localparam int TIM_W = 8;
  localparam int OFF_W = 16;
  localparam int OFF_VAL_W = 12;
  localparam int NUM_TIM = 4;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CORE_A_DUAL_TIMING_TRIM = 10'h086;
  localparam logic [IDX_W-1:0] IDX_SPARE_FOR_A_DUAL_TIMING_TRIM = 10'h087;
  localparam logic [IDX_W-1:0] IDX_SPARE_FOR_B_DUAL_TIMING_TRIM = 10'h088;
  localparam logic [IDX_W-1:0] IDX_CORE_B_DUAL_TIMING_TRIM = 10'h089;
  localparam logic [IDX_W-1:0] IDX_CORE_A_FIRST_INPUT_OFFSET_TRIM = 10'h08a;
  localparam logic [IDX_W-1:0] IDX_CORE_A_SECOND_INPUT_OFFSET_TRIM = 10'h08c;
  localparam logic [IDX_W-1:0] IDX_CAL_ACCESS_STATUS = 10'h0c0;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_RSVD_RESET = 4'h0;
  localparam int ST_WRITE_SAFE = 0;
  localparam int ST_READ_SAFE = 1;
  localparam int ST_WRITE_VIOLATION = 2;
  localparam int ST_FOREGROUND_DONE_FLAG = 3;
  localparam int ST_CALIBRATION_STOPPED_FLAG = 4;
  localparam logic [TIM_W-1:0] TIM_RESET = 8'h00;
  localparam logic [OFF_W-1:0] OFF_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [TIM_W-1:0] stotr_tim_t;
  typedef logic [OFF_W-1:0] stotr_off_t;
endpackage

// ===== stotr_regs_checker.sv
// Purpose: Port-level checks for the timing and offset trim bank
// Assumes: One clock, synchronous active-low reset
// Notes: Attached by bind from the bench top file
`timescale 1ns/10ps
module stotr_regs_checker (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [stotr_pkg::DATA_W-1:0] s_axi_rdata, // Read data
  input wire logic core_a_on_second_input, // Input select
  input wire logic [stotr_pkg::NUM_TIM*stotr_pkg::TIM_W-1:0] dual_timing_trim, // Timing trims
  input wire logic [stotr_pkg::OFF_VAL_W-1:0] core_a_offset_applied // Applied offset
);
  import stotr_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_w_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  a_w_lat: assert property (p_w_lat) else $error("write answer late");
  property p_one_out; !(s_axi_bvalid && (s_axi_awready || s_axi_wready)) && !(s_axi_rvalid && s_axi_arready); endproperty
  a_one_out: assert property (p_one_out) else $error("request taken while answer pending");
  property p_load; $rose(aresetn) |-> !s_axi_arready ##1 s_axi_arready && s_axi_awready; endproperty
  a_load: assert property (p_load) else $error("ready timing after reset wrong");
  // Only a completed write or a reload may move the timing outputs
  property p_tim_chg; $changed(dual_timing_trim) |-> $rose(s_axi_bvalid) || !$past(aresetn, 2); endproperty
  a_tim_chg: assert property (p_tim_chg) else $error("timing trim moved without write");
  property p_off_chg; $changed(core_a_offset_applied) |-> $past(s_axi_bvalid) || !$past(aresetn, 2) ||
    !$past(aresetn, 3) || $past(core_a_on_second_input) != $past(core_a_on_second_input, 2); endproperty
  a_off_chg: assert property (p_off_chg) else $error("applied offset moved without cause");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_sel: cover property ($changed(core_a_offset_applied));
endmodule

// ===== stotr_regs_test.sv
// Purpose: Self-checking bench for the trim register bank
// Assumes: AXI4-Lite master tasks, 200 MHz aclk
// Notes: Calibration flags are kept legal around offset accesses before the second reset
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module stotr_regs_test;
  import stotr_pkg::*;
  localparam logic [31:0] FT = 32'h8d6b4927;
  localparam logic [15:0] FO1 = 16'hfabc; // Upper nibble must not load
  localparam logic [15:0] FO2 = 16'h7123;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic core_a_on_second_input = 1'b0, foreground_cal_busy = 1'b0, offset_calibration_enable = 1'b0;
  logic background_calibration_enable = 1'b0, background_offset_calibration_enable = 1'b0;
  logic foreground_done_flag = 1'b0, calibration_stopped_flag = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, dual_timing_trim;
  logic [11:0] core_a_offset_applied;
  logic [31:0] factory_timing_trim = FT;
  logic [15:0] factory_first_input_offset = FO1, factory_second_input_offset = FO2;
  int n_errors = 0;
  int check_count = 0;
  stotr_regs u_dut (.*);
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ha, hw, hb;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {i, 2'b00, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      // Sample mid-cycle so the handshake seen equals what the edge takes
      @(negedge aclk);
      {ha, hw, hb, r} = {s_axi_awvalid && s_axi_awready, s_axi_wvalid && s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end while (!hb);
    // No local limit: only the watchdog may end a stalled handshake
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] i, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge aclk);
      {ha, hr, d, r} = {s_axi_arvalid && s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
    end while (!hr);
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk_rd(input logic [9:0] i, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(i, d, r);
    `CHK(d, e)
    `CHK(r, er)
  endtask
  task automatic st(input logic [5:0] c, input logic [4:0] e);
    @(posedge aclk);
    {foreground_cal_busy, background_calibration_enable, background_offset_calibration_enable,
      offset_calibration_enable, foreground_done_flag, calibration_stopped_flag} <= c;
    chk_rd(IDX_CAL_ACCESS_STATUS, {27'h0, e}, RESP_OKAY);
  endtask
  task automatic rst;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(negedge aclk);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] r;
    rst();
    for (int i = 0; i < 4; i++) chk_rd(IDX_CORE_A_DUAL_TIMING_TRIM + 10'(i), {24'h0, FT[i*8+:8]}, RESP_OKAY);
    chk_rd(IDX_CORE_A_FIRST_INPUT_OFFSET_TRIM, {20'h0, FO1[11:0]}, RESP_OKAY);
    chk_rd(IDX_CORE_A_SECOND_INPUT_OFFSET_TRIM, {20'h0, FO2[11:0]}, RESP_OKAY);
    `CHK(dual_timing_trim, FT)
    `CHK(core_a_offset_applied, FO1[11:0])
    core_a_on_second_input <= 1'b1;
    repeat (2) @(negedge aclk);
    `CHK(core_a_offset_applied, FO2[11:0])
    $display("test factory_values done");
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CORE_A_DUAL_TIMING_TRIM + 10'(i), 32'hffffffc0 + i, 4'h1, r);
      `CHK(r, RESP_OKAY)
      chk_rd(IDX_CORE_A_DUAL_TIMING_TRIM + 10'(i), 32'hc0 + i, RESP_OKAY);
    end
    `CHK(dual_timing_trim, 32'hc3c2c1c0)
    wr(IDX_CORE_B_DUAL_TIMING_TRIM, 32'h000000aa, 4'he, r);
    `CHK(r, RESP_OKAY)
    chk_rd(IDX_CORE_B_DUAL_TIMING_TRIM, 32'hc3, RESP_OKAY);
    $display("test timing_write done");
    core_a_on_second_input <= 1'b0;
    wr(IDX_CORE_A_FIRST_INPUT_OFFSET_TRIM, 32'h1234f5a6, 4'hf, r);
    chk_rd(IDX_CORE_A_FIRST_INPUT_OFFSET_TRIM, 32'h0000f5a6, RESP_OKAY);
    repeat (2) @(negedge aclk);
    `CHK(core_a_offset_applied, 12'h5a6)
    wr(10'h0ff, 32'h5a5a5a5a, 4'hf, r);
    `CHK(r, RESP_SLVERR)
    chk_rd(10'h0ff, 32'h0, RESP_SLVERR);
    $display("test offset_and_unmapped done");
    st(6'b011001, 5'h12);
    chk_rd(IDX_CORE_A_FIRST_INPUT_OFFSET_TRIM, 32'h0000f5a6, RESP_OKAY);
    st(6'b000110, 5'h0b);
    chk_rd(IDX_CORE_A_SECOND_INPUT_OFFSET_TRIM, {20'h0, FO2[11:0]}, RESP_OKAY);
    st(6'b100100, 5'h00);
    $display("test calibration_status done");
    rst();
    `CHK(dual_timing_trim, FT)
    chk_rd(IDX_CORE_A_FIRST_INPUT_OFFSET_TRIM, {20'h0, FO1[11:0]}, RESP_OKAY);
    $display("test second_reset done");
    print_verdict();
  end
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
endmodule
bind stotr_regs stotr_regs_checker u_chk (.*);
